/* File: hw/gcm_counter.sv */
// gcm_counter: one gated/ungated counter channel (modes b,d,e,f,g,h,i,j,k,o) behind an apb slave.
// assumes src_i and gate_i are synchronous to pclk and active high; counts down by one per source edge.
// Behaviour
// - mode chosen from gate-control bits 15..13 with mode bits 7..5.
// - stop or disarm applies on the source edge leaving terminal count.
// - mode b: armed, count only while gate active; reload load and disarm.
// - mode b: no counting after disarm until a new arm command.
// - mode d: gate ignored; count to terminal count repeatedly.
// - mode d: reload from load at every terminal count.
// - mode e: as mode d but counts only while gate active.
// - mode f: gate edge starts; terminal count reloads load, waits next edge.
// - mode f: gate ignored from trigger edge until terminal count.
// - mode g: count to terminal count twice, then disarm.
// - mode g: first reload from hold, second from load and disarm.
// - mode h: mode g sequence, counting only while gate active.
// - mode i: edges ignored disarmed; start after trigger edge, then mode g.
// - mode i: gate ignored from trigger until second terminal count.
// - mode j: count continuously until a disarm command.
// - mode j: reload alternates hold then load at terminal counts.
// - mode k: mode j gated by level; alternation restarts with hold on arm.
// - mode o: trigger edge needed; then counts all source edges to terminal count.
// - mode o: terminal count reloads load and disarms; needs arm then edge.
// - mode o: every gate edge while armed retriggers and copies counter into hold.
// - mode o retrigger: first source edge loads, second is skipped, third resumes counting.
// - toggle-on-terminal-count output option for square or duty-cycle waves.
`timescale 1ns/100ps
module gcm_counter
    import gcm_pkg::*;
#(
    parameter logic [2:0] GC_LEVEL = GC_LEVEL_DEF,
    parameter logic [2:0] GC_EDGE  = GC_EDGE_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        src_i,
    input  wire logic        gate_i,
    output logic             tc_out,
    output logic             armed_out
);
    gcm_apb_req_t req;
    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    logic [15:0] mode_r, mode_nxt;
    logic [15:0] load_r, load_nxt;
    logic [15:0] hold_r, hold_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    gcm_stat_t   st_r, st_nxt;
    logic        src_d_r, gate_d_r;
    logic        tc_r, tc_nxt, tgl_r, tgl_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    gcm_mode_t   mode;

    logic acc, wr, rd, hit, src_e, gate_e, qual, cmd_wr;
    logic [2:0] gc, mb;

    assign acc    = req.psel && req.penable && !pready_r;
    assign wr     = acc && req.pwrite;
    assign rd     = acc && !req.pwrite;
    assign src_e  = src_i && !src_d_r;
    assign gate_e = gate_i && !gate_d_r;
    assign gc     = mode_r[GC_HI:GC_LO];
    assign mb     = mode_r[MB_HI:MB_LO];
    assign cmd_wr = wr && (req.paddr == OFF_CMD);

    // mode decode
    always_comb begin
        mode = GCM_OFF;
        case ({gc == GC_NONE, gc == GC_LEVEL, gc == GC_EDGE})
            3'b100: begin
                case (mb)
                    MB_REP:   mode = GCM_D;
                    MB_TWICE: mode = GCM_G;
                    MB_ALT:   mode = GCM_J;
                    default:  mode = GCM_OFF;
                endcase
            end
            3'b010: begin
                case (mb)
                    MB_ONCE:  mode = GCM_B;
                    MB_REP:   mode = GCM_E;
                    MB_TWICE: mode = GCM_H;
                    MB_ALT:   mode = GCM_K;
                    default:  mode = GCM_OFF;
                endcase
            end
            3'b001: begin
                case (mb)
                    MB_REP:    mode = GCM_F;
                    MB_TWICE:  mode = GCM_I;
                    MB_RETRIG: mode = GCM_O;
                    default:   mode = GCM_OFF;
                endcase
            end
            default: mode = GCM_OFF;
        endcase
    end

    // counting engine and registers
    always_comb begin
        logic level_gated, edge_gated, tc_hit;
        level_gated = (mode == GCM_B) || (mode == GCM_E) || (mode == GCM_H) || (mode == GCM_K);
        edge_gated  = (mode == GCM_F) || (mode == GCM_I) || (mode == GCM_O);
        tc_hit      = 1'b0;
        mode_nxt    = mode_r;
        load_nxt    = load_r;
        hold_nxt    = hold_r;
        cnt_nxt     = cnt_r;
        st_nxt      = st_r;
        tc_nxt      = tc_r;
        tgl_nxt     = tgl_r;

        if (wr && req.paddr == OFF_MODE) mode_nxt = req.pwdata[15:0];
        if (wr && req.paddr == OFF_LOAD) load_nxt = req.pwdata[15:0];
        if (wr && req.paddr == OFF_HOLD) hold_nxt = req.pwdata[15:0];

        // gate qualification: level gating filters edges, edge gating needs a trigger
        qual = 1'b0;
        if (st_r.armed) begin
            if (level_gated)
                qual = gate_i;
            else if (edge_gated)
                qual = st_r.running;
            else
                qual = (mode != GCM_OFF);
        end

        // trigger edge on armed counter; disarmed edges do nothing
        if (st_r.armed && edge_gated && gate_e) begin
            if (mode == GCM_O) begin
                hold_nxt       = cnt_r;
                st_nxt.retrig  = 2'd2;
                st_nxt.running = 1'b1;
            end else if (!st_r.running) begin
                st_nxt.running = 1'b1;
            end
        end

        if (src_e) begin
            if (st_r.in_tc) begin
                // a counter in terminal count always counts; stop applied on this edge
                cnt_nxt      = cnt_r - CNT_TC_VAL;
                st_nxt.in_tc = 1'b0;
                tc_nxt       = 1'b0;
                if (st_r.disarm_pend) begin
                    st_nxt.armed       = 1'b0;
                    st_nxt.running     = 1'b0;
                    st_nxt.disarm_pend = 1'b0;
                end
                if (st_r.stop_pend) begin
                    st_nxt.running   = 1'b0;
                    st_nxt.stop_pend = 1'b0;
                end
            end else if (st_r.armed && mode == GCM_O && st_r.retrig != 2'd0) begin
                if (st_r.retrig == 2'd2) cnt_nxt = load_r;
                st_nxt.retrig = st_r.retrig - 2'd1;
            end else if (qual) begin
                if (cnt_r == CNT_TC_VAL || cnt_r == CNT_ZERO) begin
                    tc_hit       = 1'b1;
                    st_nxt.in_tc = 1'b1;
                    tc_nxt       = 1'b1;
                    cnt_nxt      = load_r;
                    case (mode)
                        GCM_B, GCM_O: st_nxt.disarm_pend = 1'b1;
                        GCM_F:        st_nxt.stop_pend   = 1'b1;
                        GCM_G, GCM_H, GCM_I: begin
                            if (!st_r.second) begin
                                cnt_nxt       = hold_r;
                                st_nxt.second = 1'b1;
                            end else begin
                                st_nxt.second      = 1'b0;
                                st_nxt.disarm_pend = 1'b1;
                            end
                        end
                        GCM_J, GCM_K: begin
                            cnt_nxt       = st_r.second ? load_r : hold_r;
                            st_nxt.second = !st_r.second;
                        end
                        default: cnt_nxt = load_r;
                    endcase
                end else begin
                    cnt_nxt = cnt_r - CNT_TC_VAL;
                end
            end
        end

        // toggle output option on each terminal count
        if (tc_hit) tgl_nxt = !tgl_r;

        if (cmd_wr && req.pwdata[CMD_LOAD]) cnt_nxt = load_r;
        if (cmd_wr && req.pwdata[CMD_DISARM]) begin
            st_nxt.armed   = 1'b0;
            st_nxt.running = 1'b0;
        end
        if (cmd_wr && req.pwdata[CMD_ARM]) begin
            st_nxt.armed       = 1'b1;
            st_nxt.second      = 1'b0;
            st_nxt.running     = 1'b0;
            st_nxt.disarm_pend = 1'b0;
            st_nxt.stop_pend   = 1'b0;
            st_nxt.retrig      = 2'd0;
        end
    end

    // apb slave: one wait state, unmapped reads zero with pslverr
    always_comb begin
        hit = 1'b1;
        prdata_nxt = prdata_r;
        case (req.paddr)
            OFF_MODE:   prdata_nxt = {16'h0000, mode_r};
            OFF_LOAD:   prdata_nxt = {16'h0000, load_r};
            OFF_HOLD:   prdata_nxt = {16'h0000, hold_r};
            OFF_CMD:    prdata_nxt = RD_ZERO;
            OFF_STATUS: prdata_nxt = {24'h000000, st_r};
            OFF_COUNT:  prdata_nxt = {16'h0000, cnt_r};
            default: begin
                hit        = 1'b0;
                prdata_nxt = RD_ZERO;
            end
        endcase
        if (!rd) prdata_nxt = prdata_r;
        pready_nxt  = acc;
        pslverr_nxt = acc && !hit;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r    <= MODE_RST;
            load_r    <= CNT_RST;
            hold_r    <= CNT_RST;
            cnt_r     <= CNT_RST;
            st_r      <= '0;
            src_d_r   <= 1'b0;
            gate_d_r  <= 1'b0;
            tc_r      <= 1'b0;
            tgl_r     <= 1'b0;
            prdata_r  <= RD_ZERO;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            mode_r    <= mode_nxt;
            load_r    <= load_nxt;
            hold_r    <= hold_nxt;
            cnt_r     <= cnt_nxt;
            st_r      <= st_nxt;
            src_d_r   <= src_i;
            gate_d_r  <= gate_i;
            tc_r      <= tc_nxt;
            tgl_r     <= tgl_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    logic armed_q_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) armed_q_r <= 1'b0;
        else          armed_q_r <= st_nxt.armed;
    end

    logic tco_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tco_r <= 1'b0;
        else          tco_r <= mode_nxt[TGL_BIT] ? tgl_nxt : tc_nxt;
    end

    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign tc_out    = tco_r;
    assign armed_out = armed_q_r;
endmodule

/* File: hw/gcm_pkg.sv */
// gcm_pkg: constants, modes, register map and carrier types for the gated counter mode engine.
// assumes a 32-bit apb slave on pclk, single counter channel, 16-bit counter.
package gcm_pkg;
    localparam int          CNT_W        = 16;
    // apb byte offsets
    localparam logic [7:0]  OFF_MODE     = 8'h00;
    localparam logic [7:0]  OFF_LOAD     = 8'h04;
    localparam logic [7:0]  OFF_HOLD     = 8'h08;
    localparam logic [7:0]  OFF_CMD      = 8'h0c;
    localparam logic [7:0]  OFF_STATUS   = 8'h10;
    localparam logic [7:0]  OFF_COUNT    = 8'h14;
    // mode register field positions
    localparam int          GC_HI        = 15;
    localparam int          GC_LO        = 13;
    localparam int          MB_HI        = 7;
    localparam int          MB_LO        = 5;
    localparam int          TGL_BIT      = 0;
    // gate control codes; real bit values are not printed, so the level and edge codes are module parameters
    localparam logic [2:0]  GC_NONE      = 3'h0;
    localparam logic [2:0]  GC_LEVEL_DEF = 3'h1;
    localparam logic [2:0]  GC_EDGE_DEF  = 3'h2;
    // low mode bits: special gate, reload source, repetition
    localparam logic [2:0]  MB_ONCE      = 3'h0;
    localparam logic [2:0]  MB_REP       = 3'h1;
    localparam logic [2:0]  MB_TWICE     = 3'h2;
    localparam logic [2:0]  MB_ALT       = 3'h3;
    localparam logic [2:0]  MB_RETRIG    = 3'h4;
    // command bits
    localparam int          CMD_ARM      = 0;
    localparam int          CMD_DISARM   = 1;
    localparam int          CMD_LOAD     = 2;
    localparam logic [15:0] MODE_RST     = 16'h0b00;
    localparam logic [15:0] CNT_RST      = 16'h0000;
    localparam logic [15:0] CNT_TC_VAL   = 16'h0001;
    localparam logic [15:0] CNT_ZERO     = 16'h0000;
    localparam logic [31:0] RD_ZERO      = 32'h0000_0000;

    typedef enum {
        GCM_OFF, GCM_B, GCM_D, GCM_E, GCM_F, GCM_G, GCM_H, GCM_I, GCM_J, GCM_K, GCM_O
    } gcm_mode_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } gcm_apb_req_t;

    typedef struct packed {
        logic        armed;
        logic        running;
        logic        second;
        logic        in_tc;
        logic        stop_pend;
        logic        disarm_pend;
        logic [1:0]  retrig;
    } gcm_stat_t;
endpackage

/* File: testbench/gcm_counter_asserts.sv */
// gcm_counter_asserts: apb and counter checks for gcm_counter.
// assumes only the top-level ports; the master holds each request until pready.
`timescale 1ns/100ps
module gcm_counter_asserts
    import gcm_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        src_i,
    input wire logic        gate_i,
    input wire logic        tc_out,
    input wire logic        armed_out
);
    logic acc;
    logic cmd_wr;
    logic arm_wr;
    logic mode_wr;
    assign acc    = psel && penable && !pready;
    // switching the toggle option moves tc_out with no source edge
    assign mode_wr = acc && pwrite && (paddr == OFF_MODE);
    assign cmd_wr = acc && pwrite && (paddr == OFF_CMD);
    assign arm_wr = cmd_wr && pwdata[CMD_ARM];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_one_wait: assert property (acc |=> pready) else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_unmapped_err: assert property (acc && paddr > OFF_COUNT |=> pslverr) else $error("no pslverr");
    a_mapped_ok: assert property (acc && paddr <= OFF_COUNT && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("pslverr on mapped");
    a_cmd_reads_zero: assert property (acc && !pwrite && paddr == OFF_CMD |=> prdata == RD_ZERO)
        else $error("command read not zero");
    a_arm_sets_armed: assert property (arm_wr |-> ##[1:3] armed_out) else $error("arm lost");
    a_disarm_clears: assert property (cmd_wr && pwdata[2:0] == 3'h2 |-> ##[1:3] !armed_out)
        else $error("disarm lost");
    a_armed_needs_cmd: assert property ($rose(armed_out) |->
        $past(arm_wr) || $past(arm_wr, 2) || $past(arm_wr, 3)) else $error("armed without command");
    a_tc_after_src: assert property ($rose(tc_out) && !$past(mode_wr) |->
        ($past(src_i) && !$past(src_i, 2)) || ($past(src_i, 2) && !$past(src_i, 3)) ||
        ($past(src_i, 3) && !$past(src_i, 4))) else $error("tc without source edge");
endmodule

bind gcm_counter gcm_counter_asserts gcm_counter_asserts_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_i(src_i),
    .gate_i(gate_i), .tc_out(tc_out), .armed_out(armed_out));

/* File: testbench/testbench.sv */
// testbench: table-driven runs of each counting mode over apb.
// assumes gcm_counter with default gate codes and the bound checker.
`timescale 1ns/100ps
module testbench
    import gcm_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, src_i, gate_i;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        pready, pslverr, tc_out, armed_out, err;
    logic        tc_prev = 1'b0;
    int          mismatches = 0, total_checks = 0, tc_cnt = 0;

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end

    gcm_counter gcm_counter_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_i(src_i), .gate_i(gate_i), .tc_out(tc_out), .armed_out(armed_out));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // rising tc_out counted, so toggle and pulse outputs share one measure
    always @(posedge pclk) begin
        tc_prev <= tc_out;
        if (tc_out === 1'b1 && tc_prev === 1'b0) tc_cnt <= tc_cnt + 1;
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            mismatches++;
            report_and_stop;
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // disarm before the mode write: mode changes while armed are unsafe
    task run(input logic [2:0] gc, input logic [2:0] mb, input logic tgl, input logic [15:0] ld,
             input logic [15:0] hd, input logic g, input int n, input int exp_tc, input logic exp_arm);
        int start;
        gate_i <= 1'b0;
        apb(1'b1, OFF_CMD, 32'h0000_0002);
        apb(1'b1, OFF_MODE, {16'h0000, gc, 5'h00, mb, 4'h0, tgl});
        apb(1'b1, OFF_LOAD, {16'h0000, ld});
        apb(1'b1, OFF_HOLD, {16'h0000, hd});
        apb(1'b1, OFF_CMD, 32'h0000_0005);
        gate_i <= g;
        start = tc_cnt;
        repeat (n) begin
            @(posedge pclk);
            src_i <= 1'b1;
            @(posedge pclk);
            src_i <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        `CHK(tc_cnt - start, exp_tc)
        `CHK(armed_out, exp_arm)
    endtask

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        src_i = 1'b0;
        gate_i = 1'b0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_MODE, 32'h0000_0000);
        `CHK(rdat, {16'h0000, MODE_RST})
        apb(1'b0, 8'h20, 32'h0000_0000);
        `CHK(err, 1'b1)
        `CHK(rdat, RD_ZERO)
        run(GC_NONE, MB_REP, 1'b0, 16'h3, 16'h0, 1'b0, 9, 3, 1'b1);
        // toggle starts high after three toggles; the stale terminal count edge still counts down, so three toggles give one rise
        run(GC_NONE, MB_REP, 1'b1, 16'h3, 16'h0, 1'b0, 9, 1, 1'b1);
        run(GC_LEVEL_DEF, MB_REP, 1'b0, 16'h3, 16'h0, 1'b0, 6, 0, 1'b1);
        run(GC_LEVEL_DEF, MB_REP, 1'b0, 16'h3, 16'h0, 1'b1, 6, 2, 1'b1);
        run(GC_LEVEL_DEF, MB_ONCE, 1'b0, 16'h2, 16'h0, 1'b1, 7, 1, 1'b0);
        run(GC_NONE, MB_TWICE, 1'b0, 16'h2, 16'h3, 1'b0, 9, 2, 1'b0);
        run(GC_LEVEL_DEF, MB_TWICE, 1'b0, 16'h2, 16'h3, 1'b0, 6, 0, 1'b1);
        run(GC_LEVEL_DEF, MB_TWICE, 1'b0, 16'h2, 16'h3, 1'b1, 9, 2, 1'b0);
        run(GC_EDGE_DEF, MB_TWICE, 1'b0, 16'h2, 16'h3, 1'b0, 6, 0, 1'b1);
        run(GC_EDGE_DEF, MB_TWICE, 1'b0, 16'h2, 16'h3, 1'b1, 9, 2, 1'b0);
        run(GC_EDGE_DEF, MB_REP, 1'b0, 16'h2, 16'h0, 1'b0, 4, 0, 1'b1);
        run(GC_EDGE_DEF, MB_REP, 1'b0, 16'h2, 16'h0, 1'b1, 7, 1, 1'b1);
        run(GC_NONE, MB_ALT, 1'b0, 16'h2, 16'h4, 1'b0, 12, 4, 1'b1);
        apb(1'b1, OFF_CMD, 32'h0000_0002);
        repeat (2) @(posedge pclk);
        `CHK(armed_out, 1'b0)
        run(GC_LEVEL_DEF, MB_ALT, 1'b0, 16'h2, 16'h4, 1'b1, 8, 3, 1'b1);
        run(GC_LEVEL_DEF, MB_ALT, 1'b0, 16'h2, 16'h4, 1'b1, 5, 1, 1'b1);
        run(GC_EDGE_DEF, MB_RETRIG, 1'b0, 16'h3, 16'h0, 1'b1, 4, 0, 1'b1);
        apb(1'b0, OFF_HOLD, 32'h0000_0000);
        `CHK(rdat, 32'h0000_0003)
        run(GC_EDGE_DEF, MB_RETRIG, 1'b0, 16'h3, 16'h0, 1'b1, 6, 1, 1'b0);
        // left last: it ends inside terminal count with a disarm pending
        run(GC_LEVEL_DEF, MB_ONCE, 1'b0, 16'h2, 16'h0, 1'b1, 2, 1, 1'b1);
        report_and_stop;
    end
endmodule
